// File: design/csp_clock_steer.sv
// Clock steering pulse control with Avalon-MM register slave.
// Summary of operation
// - Steering enabled after reset by default.
// - Switch code 0 forbids, 1 permits; last wins.
// - Steering with external reference owns output pin.
// - Calibration values drive oscillator only while steering.
// - Calibration kept retained; restored only with option.
// - Factory restore without option keeps calibration.
// - Mode 0 stores, 1 auto-calibrates, 2 aborts.
// - Auto mode measures slope, zero-drift width, stores.
// - Period counts 25 ns steps; default 4400.
// - Width within 10-90 percent of period; default 2200.
// - Internal oscillator steered unless external selected.
// - Steering disabled leaves drift uncorrected.
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module csp_clock_steer #(
  parameter int unsigned PER_W = csp_pkg::PER_W,
  parameter int unsigned DRIFT_W = csp_pkg::DRIFT_W
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Avalon-MM slave
  input  wire logic [7:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  output logic      [31:0]        readdata,
  output logic                    waitrequest,
  // Drift measurements from the receiver
  input  wire logic               driftValid,
  input  wire logic signed [DRIFT_W-1:0] drift,
  // Oscillator controls
  output logic                    variable_freq_out,
  output logic                    intTuneEn,
  output logic      [PER_W-1:0]   intTuneWidth
);
  if (PER_W < 19 || PER_W > 28 || DRIFT_W < 2 || DRIFT_W > 32) begin : g_param_check
    $error("csp_clock_steer: unsupported width parameters");
  end

  csp_nvm_if nvmBus ();
  csp_nvm u_nvm (.clk_sys(clk_sys), .nvm(nvmBus.mem));

  // Accepts a width only inside 10 to 90 percent of the period.
  function automatic logic widthOk(input logic [PER_W-1:0] p, input logic [PER_W-1:0] w);
    logic [PER_W+3:0] w10;
    logic [PER_W+3:0] p1;
    logic [PER_W+3:0] p9;
    w10 = (PER_W+4)'(w) * (PER_W+4)'(10);
    p1  = (PER_W+4)'(p);
    p9  = (PER_W+4)'(p) * (PER_W+4)'(9);
    return (w10 >= p1) && (w10 <= p9);
  endfunction

  csp_pkg::csp_state_t stateQ;
  logic               ackQ;
  logic               steerEnQ, extSelQ, manEnQ;
  logic [PER_W-1:0]   calPeriodQ, calWidthQ, manPeriodQ, manWidthQ;
  logic [31:0]        calSlopeQ, calBwQ;
  logic [PER_W-1:0]   actPeriodQ, actWidthQ;
  logic [31:0]        actSlopeQ, actBwQ;
  logic [1:0]         idxQ;
  logic               bootCapQ;
  logic [1:0]         bootIdxQ;
  logic signed [DRIFT_W-1:0] drift0Q;
  logic signed [DRIFT_W:0]   slopeMeas;
  logic [6:0]         accQ;
  logic               tickQ;
  logic [PER_W-1:0]   cntQ, curPerQ, curWidQ;
  logic               ownsPin, wrAcc, rdAcc, boundary, calBusy;
  logic [1:0]         calMode;
  logic               facRestore, facCalOpt;

  assign wrAcc      = write && ackQ;
  assign rdAcc      = read && !ackQ;
  assign ownsPin    = steerEnQ && extSelQ;
  assign calMode    = writedata[1:0];
  assign facRestore = wrAcc && address == csp_pkg::OFF_FACTORY
                      && writedata[csp_pkg::FAC_RESTORE_BIT];
  assign facCalOpt  = writedata[csp_pkg::FAC_CALOPT_BIT];
  assign calBusy    = stateQ == csp_pkg::CSP_MEAS0 || stateQ == csp_pkg::CSP_MEAS1
                      || stateQ == csp_pkg::CSP_SEEK;
  assign slopeMeas  = (DRIFT_W+1)'(drift) - (DRIFT_W+1)'(drift0Q);

  // Answer one cycle after the request is seen, then drop waitrequest for one cycle.
  // The pin is a flop of its own so the master never sees a decoded glitch.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end
  assign ackQ = !waitrequest;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      readdata <= 32'h00000000;
    end else if (rdAcc) begin
      unique case (address)
        csp_pkg::OFF_CTRL:       readdata <= {29'h0, manEnQ, extSelQ, steerEnQ};
        csp_pkg::OFF_CAL_PERIOD: readdata <= 32'(calPeriodQ);
        csp_pkg::OFF_CAL_WIDTH:  readdata <= 32'(calWidthQ);
        csp_pkg::OFF_CAL_SLOPE:  readdata <= calSlopeQ;
        csp_pkg::OFF_CAL_BW:     readdata <= calBwQ;
        csp_pkg::OFF_MAN_PERIOD: readdata <= 32'(manPeriodQ);
        csp_pkg::OFF_MAN_WIDTH:  readdata <= 32'(manWidthQ);
        csp_pkg::OFF_STATUS:     readdata <= {26'h0, stateQ, !extSelQ && steerEnQ,
                                              calBusy, ownsPin};
        csp_pkg::OFF_ACT_PERIOD: readdata <= 32'(actPeriodQ);
        csp_pkg::OFF_ACT_WIDTH:  readdata <= 32'(actWidthQ);
        csp_pkg::OFF_ACT_SLOPE:  readdata <= actSlopeQ;
        default:                 readdata <= 32'h00000000;
      endcase
    end
  end

  // Steering switch, reference select and manual output enable.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      steerEnQ <= csp_pkg::STEER_ENABLE;
      extSelQ  <= 1'b0;
      manEnQ   <= 1'b0;
    end else if (wrAcc && address == csp_pkg::OFF_CTRL) begin
      steerEnQ <= writedata[csp_pkg::CTRL_STEER_BIT];
      extSelQ  <= writedata[csp_pkg::CTRL_EXT_BIT];
      manEnQ   <= writedata[csp_pkg::CTRL_MAN_BIT];
    end
  end

  // Staged calibration values; a width outside the legal band is dropped.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      calPeriodQ <= PER_W'(csp_pkg::PERIOD_DEFAULT);
      calWidthQ  <= PER_W'(csp_pkg::WIDTH_DEFAULT);
      calSlopeQ  <= csp_pkg::SLOPE_DEFAULT;
      calBwQ     <= csp_pkg::BW_DEFAULT;
    end else if (facRestore && facCalOpt) begin
      calPeriodQ <= PER_W'(csp_pkg::PERIOD_DEFAULT);
      calWidthQ  <= PER_W'(csp_pkg::WIDTH_DEFAULT);
      calSlopeQ  <= csp_pkg::SLOPE_DEFAULT;
      calBwQ     <= csp_pkg::BW_DEFAULT;
    end else if (wrAcc) begin
      if (address == csp_pkg::OFF_CAL_PERIOD && writedata <= 32'(csp_pkg::PERIOD_MAX)) begin
        calPeriodQ <= writedata[PER_W-1:0];
      end
      if (address == csp_pkg::OFF_CAL_WIDTH && widthOk(calPeriodQ, writedata[PER_W-1:0])) begin
        calWidthQ <= writedata[PER_W-1:0];
      end
      if (address == csp_pkg::OFF_CAL_SLOPE) begin
        calSlopeQ <= writedata;
      end
      if (address == csp_pkg::OFF_CAL_BW) begin
        calBwQ <= writedata;
      end
    end
  end

  // Manual frequency output settings.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      manPeriodQ <= PER_W'(csp_pkg::PERIOD_DEFAULT);
      manWidthQ  <= PER_W'(csp_pkg::WIDTH_DEFAULT);
    end else if (wrAcc) begin
      if (address == csp_pkg::OFF_MAN_PERIOD && writedata <= 32'(csp_pkg::PERIOD_MAX)) begin
        manPeriodQ <= writedata[PER_W-1:0];
      end
      if (address == csp_pkg::OFF_MAN_WIDTH && widthOk(manPeriodQ, writedata[PER_W-1:0])) begin
        manWidthQ <= writedata[PER_W-1:0];
      end
    end
  end

  // Sequencer: boot load from storage, calibration and store.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stateQ <= csp_pkg::CSP_BOOT;
      idxQ   <= 2'h0;
    end else begin
      unique case (stateQ)
        csp_pkg::CSP_BOOT: begin
          idxQ <= idxQ + 2'h1;
          if (idxQ == 2'h3) begin
            stateQ <= csp_pkg::CSP_IDLE;
          end
        end
        csp_pkg::CSP_IDLE: begin
          idxQ <= 2'h0;
          if (facRestore && facCalOpt) begin
            stateQ <= csp_pkg::CSP_STORE;
          end else if (wrAcc && address == csp_pkg::OFF_CAL_CMD) begin
            if (calMode == csp_pkg::CAL_MODE_SET) begin
              stateQ <= csp_pkg::CSP_STORE;
            end else if (calMode == csp_pkg::CAL_MODE_AUTO) begin
              stateQ <= csp_pkg::CSP_MEAS0;
            end
          end
        end
        csp_pkg::CSP_MEAS0, csp_pkg::CSP_MEAS1, csp_pkg::CSP_SEEK: begin
          if (wrAcc && address == csp_pkg::OFF_CAL_CMD && calMode == csp_pkg::CAL_MODE_OFF) begin
            stateQ <= csp_pkg::CSP_IDLE;
          end else if (driftValid) begin
            if (stateQ == csp_pkg::CSP_MEAS0) begin
              stateQ <= csp_pkg::CSP_MEAS1;
            end else if (stateQ == csp_pkg::CSP_MEAS1) begin
              stateQ <= (slopeMeas == '0) ? csp_pkg::CSP_STORE : csp_pkg::CSP_SEEK;
            end else if (drift == '0 || (drift[DRIFT_W-1] != drift0Q[DRIFT_W-1])
                         || !widthOk(actPeriodQ, actWidthQ)) begin
              stateQ <= csp_pkg::CSP_STORE;
            end
          end
        end
        csp_pkg::CSP_STORE: begin
          idxQ <= idxQ + 2'h1;
          if (idxQ == 2'h3) begin
            stateQ <= csp_pkg::CSP_IDLE;
          end
        end
        default: stateQ <= csp_pkg::CSP_IDLE;
      endcase
    end
  end

  // Storage port: words are written only while storing.
  assign nvmBus.wrEn  = stateQ == csp_pkg::CSP_STORE;
  assign nvmBus.addr  = idxQ;
  always_comb begin
    unique case (idxQ)
      csp_pkg::NVM_PERIOD: nvmBus.wdata = 32'(actPeriodQ);
      csp_pkg::NVM_WIDTH:  nvmBus.wdata = 32'(actWidthQ);
      csp_pkg::NVM_SLOPE:  nvmBus.wdata = actSlopeQ;
      default:             nvmBus.wdata = actBwQ;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bootCapQ <= 1'b0;
      bootIdxQ <= 2'h0;
    end else begin
      bootCapQ <= stateQ == csp_pkg::CSP_BOOT;
      bootIdxQ <= idxQ;
    end
  end

  // Live steering values: loaded at boot, replaced by set, trimmed by auto calibration.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      actPeriodQ <= PER_W'(csp_pkg::PERIOD_DEFAULT);
      actWidthQ  <= PER_W'(csp_pkg::WIDTH_DEFAULT);
      actSlopeQ  <= csp_pkg::SLOPE_DEFAULT;
      actBwQ     <= csp_pkg::BW_DEFAULT;
      drift0Q    <= '0;
    end else if (bootCapQ) begin
      unique case (bootIdxQ)
        csp_pkg::NVM_PERIOD: actPeriodQ <= nvmBus.rdata[PER_W-1:0];
        csp_pkg::NVM_WIDTH:  actWidthQ  <= nvmBus.rdata[PER_W-1:0];
        csp_pkg::NVM_SLOPE:  actSlopeQ  <= nvmBus.rdata;
        default:             actBwQ     <= nvmBus.rdata;
      endcase
    end else if (stateQ == csp_pkg::CSP_IDLE && (facRestore && facCalOpt)) begin
      actPeriodQ <= PER_W'(csp_pkg::PERIOD_DEFAULT);
      actWidthQ  <= PER_W'(csp_pkg::WIDTH_DEFAULT);
      actSlopeQ  <= csp_pkg::SLOPE_DEFAULT;
      actBwQ     <= csp_pkg::BW_DEFAULT;
    end else if (stateQ == csp_pkg::CSP_IDLE && wrAcc && address == csp_pkg::OFF_CAL_CMD
                 && calMode != csp_pkg::CAL_MODE_OFF) begin
      actPeriodQ <= calPeriodQ;
      actWidthQ  <= calWidthQ;
      actSlopeQ  <= calSlopeQ;
      actBwQ     <= calBwQ;
    end else if (driftValid && stateQ == csp_pkg::CSP_MEAS0) begin
      drift0Q   <= drift;
      actWidthQ <= actWidthQ + 1'b1;
    end else if (driftValid && stateQ == csp_pkg::CSP_MEAS1) begin
      actSlopeQ <= 32'(signed'(slopeMeas));
      drift0Q   <= drift;
    end else if (driftValid && stateQ == csp_pkg::CSP_SEEK && drift != '0
                 && drift[DRIFT_W-1] == drift0Q[DRIFT_W-1]) begin
      // Step one count against the drift: the width moves in the sign of minus drift over slope.
      if (drift[DRIFT_W-1] == actSlopeQ[31]) begin
        actWidthQ <= actWidthQ - 1'b1;
      end else begin
        actWidthQ <= actWidthQ + 1'b1;
      end
    end
  end

  // Internal oscillator tuning word, held only while steering the internal source.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      intTuneEn    <= 1'b0;
      intTuneWidth <= '0;
    end else begin
      intTuneEn    <= steerEnQ && !extSelQ;
      intTuneWidth <= (steerEnQ && !extSelQ) ? actWidthQ : '0;
    end
  end

  // Fractional divider: 40 ticks per 100 system cycles give the 25 ns step.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      accQ  <= 7'h00;
      tickQ <= 1'b0;
    end else if (accQ + 7'(csp_pkg::ACC_INC) >= 7'(csp_pkg::ACC_MOD)) begin
      accQ  <= accQ + 7'(csp_pkg::ACC_INC) - 7'(csp_pkg::ACC_MOD);
      tickQ <= 1'b1;
    end else begin
      accQ  <= accQ + 7'(csp_pkg::ACC_INC);
      tickQ <= 1'b0;
    end
  end

  // A period of zero keeps the pin low; new settings wait for the period boundary.
  assign boundary = tickQ && (curPerQ == '0 || cntQ >= curPerQ - 1'b1);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cntQ    <= '0;
      curPerQ <= '0;
      curWidQ <= '0;
    end else if (boundary) begin
      cntQ <= '0;
      if (ownsPin) begin
        curPerQ <= actPeriodQ;
        curWidQ <= actWidthQ;
      end else if (manEnQ) begin
        curPerQ <= manPeriodQ;
        curWidQ <= manWidthQ;
      end else begin
        curPerQ <= '0;
        curWidQ <= '0;
      end
    end else if (tickQ) begin
      cntQ <= cntQ + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      variable_freq_out <= 1'b0;
    end else begin
      variable_freq_out <= (curPerQ != '0) && (cntQ < curWidQ);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_reset_steer;
    $fell(rst) |-> steerEnQ && !extSelQ;
  endproperty
  a_reset_steer: assert property (p_reset_steer) else $error("steering not on after reset");

  property p_switch;
    wrAcc && address == csp_pkg::OFF_CTRL |=> steerEnQ == $past(writedata[0]);
  endproperty
  a_switch: assert property (p_switch) else $error("switch write not honoured");

  property p_owner_reload;
    boundary && ownsPin |=> curPerQ == $past(actPeriodQ) && curWidQ == $past(actWidthQ);
  endproperty
  a_owner_reload: assert property (p_owner_reload) else $error("steering lost the pin");

  property p_idle_pin;
    boundary && !steerEnQ && !manEnQ |=> curPerQ == '0 ##1 !variable_freq_out;
  endproperty
  a_idle_pin: assert property (p_idle_pin) else $error("pin driven without source");

  property p_store_only;
    nvmBus.wrEn |-> stateQ == csp_pkg::CSP_STORE;
  endproperty
  a_store_only: assert property (p_store_only) else $error("storage written outside store");

  property p_plain_restore;
    facRestore && !facCalOpt && stateQ == csp_pkg::CSP_IDLE |=> stateQ == csp_pkg::CSP_IDLE;
  endproperty
  a_plain_restore: assert property (p_plain_restore) else $error("plain restore stored");

  property p_abort;
    calBusy && wrAcc && address == csp_pkg::OFF_CAL_CMD && calMode == csp_pkg::CAL_MODE_OFF
      |=> stateQ == csp_pkg::CSP_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("calibration not aborted");

  property p_slope;
    stateQ == csp_pkg::CSP_MEAS1 && driftValid && !wrAcc
      |=> actSlopeQ == 32'(signed'($past(slopeMeas)));
  endproperty
  a_slope: assert property (p_slope) else $error("measured slope wrong");

  property p_tick_rate;
    !$past(rst) && !tickQ ##1 !tickQ |=> tickQ;
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("step tick too slow");

  property p_width_band;
    wrAcc && address == csp_pkg::OFF_CAL_WIDTH && !widthOk(calPeriodQ, writedata[PER_W-1:0])
      && !facRestore |=> $stable(calWidthQ);
  endproperty
  a_width_band: assert property (p_width_band) else $error("illegal width accepted");

  property p_manual;
    boundary && !ownsPin && manEnQ |=> curPerQ == $past(manPeriodQ);
  endproperty
  a_manual: assert property (p_manual) else $error("manual setting not applied");

  property p_no_correct;
    !steerEnQ |=> !intTuneEn && intTuneWidth == '0;
  endproperty
  a_no_correct: assert property (p_no_correct) else $error("tuning while disabled");

  c_auto_done: cover property (stateQ == csp_pkg::CSP_SEEK ##1 stateQ == csp_pkg::CSP_STORE);
  c_cal_restore: cover property (facRestore && facCalOpt);
  c_own_pin: cover property ($rose(ownsPin));
  c_pulse: cover property ($rose(variable_freq_out));
endmodule

// File: design/csp_pkg.sv
// Package with register map, reset values and timing constants of the clock steering block.
package csp_pkg;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned PER_W         = 19;
  localparam int unsigned DRIFT_W       = 16;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_CAL_CMD    = 8'h04;
  localparam logic [7:0] OFF_CAL_PERIOD = 8'h08;
  localparam logic [7:0] OFF_CAL_WIDTH  = 8'h0C;
  localparam logic [7:0] OFF_CAL_SLOPE  = 8'h10;
  localparam logic [7:0] OFF_CAL_BW     = 8'h14;
  localparam logic [7:0] OFF_MAN_PERIOD = 8'h18;
  localparam logic [7:0] OFF_MAN_WIDTH  = 8'h1C;
  localparam logic [7:0] OFF_FACTORY    = 8'h20;
  localparam logic [7:0] OFF_STATUS     = 8'h24;
  localparam logic [7:0] OFF_ACT_PERIOD = 8'h28;
  localparam logic [7:0] OFF_ACT_WIDTH  = 8'h2C;
  localparam logic [7:0] OFF_ACT_SLOPE  = 8'h30;

  // Field positions.
  localparam int unsigned CTRL_STEER_BIT  = 0;
  localparam int unsigned CTRL_EXT_BIT    = 1;
  localparam int unsigned CTRL_MAN_BIT    = 2;
  localparam int unsigned FAC_RESTORE_BIT = 0;
  localparam int unsigned FAC_CALOPT_BIT  = 1;
  localparam int unsigned ST_OWN_BIT      = 0;
  localparam int unsigned ST_BUSY_BIT     = 1;
  localparam int unsigned ST_INT_BIT      = 2;

  // Steering switch and calibration mode codes.
  localparam logic       STEER_DISABLE  = 1'b0;
  localparam logic       STEER_ENABLE   = 1'b1;
  localparam logic [1:0] CAL_MODE_SET   = 2'h0;
  localparam logic [1:0] CAL_MODE_AUTO  = 2'h1;
  localparam logic [1:0] CAL_MODE_OFF   = 2'h2;

  // Reset and factory values.
  localparam logic [PER_W-1:0]   PERIOD_DEFAULT = 19'h01130;
  localparam logic [PER_W-1:0]   WIDTH_DEFAULT  = 19'h00898;
  localparam logic [PER_W-1:0]   PERIOD_MAX     = 19'h40000;
  localparam logic [DATA_W-1:0]  SLOPE_DEFAULT  = 32'h00000000;
  localparam logic [DATA_W-1:0]  BW_DEFAULT     = 32'h00000000;

  // Calibration storage word indices.
  localparam logic [1:0] NVM_PERIOD = 2'h0;
  localparam logic [1:0] NVM_WIDTH  = 2'h1;
  localparam logic [1:0] NVM_SLOPE  = 2'h2;
  localparam logic [1:0] NVM_BW     = 2'h3;

  // Pulse timing base: 25 ns steps derived from the system clock.
  localparam int unsigned STEP_NS     = 25;
  localparam int unsigned SYS_NS      = 10;
  localparam int unsigned BASE_HZ     = 40_000_000;
  localparam int unsigned SYS_HZ      = 100_000_000;
  localparam int unsigned ACC_INC     = BASE_HZ / 1_000_000;
  localparam int unsigned ACC_MOD     = SYS_HZ / 1_000_000;

  typedef enum logic [2:0] {
    CSP_BOOT  = 3'b000,
    CSP_IDLE  = 3'b001,
    CSP_MEAS0 = 3'b011,
    CSP_MEAS1 = 3'b010,
    CSP_SEEK  = 3'b110,
    CSP_STORE = 3'b111
  } csp_state_t;
endpackage

// File: design/csp_nvm_if.sv
// Interface between the steering control and its calibration storage.
`timescale 1ns/100ps
interface csp_nvm_if;
  logic        wrEn;
  logic [1:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport ctrl (output wrEn, output addr, output wdata, input rdata);
  modport mem  (input wrEn, input addr, input wdata, output rdata);
endinterface

// File: design/csp_nvm.sv
// Retained storage for steering calibration words, registered read data.
`timescale 1ns/100ps
module csp_nvm (
  // Clock
  input  wire logic clk_sys,
  // Storage port
  csp_nvm_if.mem    nvm
);
  // Contents are not touched by the system reset: they model retained storage.
  // Word order follows the storage indices: period, width, slope, bandwidth.
  logic [31:0] memQ [4] = '{32'(csp_pkg::PERIOD_DEFAULT), 32'(csp_pkg::WIDTH_DEFAULT),
                            csp_pkg::SLOPE_DEFAULT, csp_pkg::BW_DEFAULT};

  always_ff @(posedge clk_sys) begin
    if (nvm.wrEn) begin
      memQ[nvm.addr] <= nvm.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    nvm.rdata <= memQ[nvm.addr];
  end
endmodule

// File: bench/csp_ext_osc_model.sv
// Behavioural external oscillator behind a charge pump, reporting drift per pulse period.
`timescale 1ns/100ps
module csp_ext_osc_model #(
  parameter int ZERO_HI = 105
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Steering pulse input
  input  wire logic               en,
  input  wire logic               pin,
  // Drift report
  output logic                    driftValid,
  output logic signed [15:0]      drift
);
  int   hiCnt;
  logic pinQ;

  // Drift falls as the high time grows, so the slope seen by the design is negative.
  // The report follows the end of each high phase, so a width step made in the low
  // phase is already visible in the next report.
  always_ff @(posedge clk_sys) begin
    pinQ <= pin;
    driftValid <= 1'b0;
    if (rst) begin
      hiCnt <= 0;
      drift <= 16'h0000;
    end else if (!pin && pinQ) begin
      driftValid <= en;
      drift <= 16'(ZERO_HI - hiCnt);
    end else if (pin && !pinQ) begin
      hiCnt <= 0;
    end else if (pin) begin
      hiCnt <= hiCnt + 1;
    end
  end
endmodule

// File: bench/csp_clock_steer_tb.sv
// Self-checking bench for the clock steering pulse control.
`timescale 1ns/100ps
module csp_clock_steer_tb;
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic [7:0]         address = 8'h00;
  logic               read = 1'b0;
  logic               write = 1'b0;
  logic               en = 1'b0;
  logic [31:0]        writedata = 32'h0;
  logic [31:0]        readdata;
  logic [31:0]        q;
  logic               waitrequest;
  logic               driftValid;
  logic               vfo;
  logic               tuneEn;
  logic signed [15:0] drift;
  logic [18:0]        tuneW;
  int                 failures = 0;
  int                 n_tests = 0;

  initial forever #5 clk_sys = ~clk_sys;

  csp_clock_steer DUT (.clk_sys, .rst, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .driftValid, .drift, .variable_freq_out(vfo), .intTuneEn(tuneEn),
    .intTuneWidth(tuneW));
  csp_ext_osc_model osc (.clk_sys, .rst, .en, .pin(vfo), .driftValid, .drift);

  task automatic stop_test;
    $display("Comparisons %0d, failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // One edge passes first so a released strobe is never raised in the same step.
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) begin
      failures++;
      stop_test;
    end
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  task automatic wt(input logic v, output int c);
    c = 0;
    while (vfo !== v) begin
      @(posedge clk_sys);
      c++;
      if (c > 15000) begin
        failures++;
        stop_test;
      end
    end
  endtask

  task automatic meas(input int ep, input int eh);
    int c, h, l;
    wt(1'b0, c);
    wt(1'b1, c);
    wt(1'b0, h);
    wt(1'b1, l);
    chk("pin high", 32'(eh), 32'(h));
    chk("pin period", 32'(ep), 32'(h + l));
  endtask

  task automatic t_reset;
    rdc("ctrl", csp_pkg::OFF_CTRL, 32'h1);
    rdc("cal period", csp_pkg::OFF_CAL_PERIOD, 32'h1130);
    rdc("cal width", csp_pkg::OFF_CAL_WIDTH, 32'h898);
    rdc("unmapped", 8'h40, 32'h0);
    chk("tune en", 32'h1, {31'h0, tuneEn});
  endtask

  task automatic t_switch;
    acc(1'b1, csp_pkg::OFF_CTRL, 32'h0);
    rdc("ctrl off", csp_pkg::OFF_CTRL, 32'h0);
    chk("tune off", 32'h0, {12'h0, tuneEn, tuneW});
    acc(1'b1, csp_pkg::OFF_CTRL, 32'h1);
    rdc("ctrl on", csp_pkg::OFF_CTRL, 32'h1);
    chk("tune on", {12'h0, 1'b1, 19'h898}, {12'h0, tuneEn, tuneW});
  endtask

  task automatic t_range;
    acc(1'b1, csp_pkg::OFF_CAL_WIDTH, 32'h1B7);
    rdc("width low", csp_pkg::OFF_CAL_WIDTH, 32'h898);
    acc(1'b1, csp_pkg::OFF_CAL_WIDTH, 32'hF79);
    rdc("width high", csp_pkg::OFF_CAL_WIDTH, 32'h898);
    acc(1'b1, csp_pkg::OFF_CAL_PERIOD, 32'h40001);
    rdc("period max", csp_pkg::OFF_CAL_PERIOD, 32'h1130);
    acc(1'b1, csp_pkg::OFF_CAL_WIDTH, 32'h1B8);
    rdc("width edge", csp_pkg::OFF_CAL_WIDTH, 32'h1B8);
  endtask

  task automatic t_manual;
    acc(1'b1, csp_pkg::OFF_MAN_PERIOD, 32'h28);
    acc(1'b1, csp_pkg::OFF_MAN_WIDTH, 32'h14);
    acc(1'b1, csp_pkg::OFF_CTRL, 32'h4);
    meas(100, 50);
  endtask

  task automatic t_cal;
    acc(1'b1, csp_pkg::OFF_CTRL, 32'h6);
    acc(1'b1, csp_pkg::OFF_CTRL, 32'h7);
    acc(1'b1, csp_pkg::OFF_CAL_PERIOD, 32'h50);
    acc(1'b1, csp_pkg::OFF_CAL_WIDTH, 32'h28);
    acc(1'b1, csp_pkg::OFF_CAL_CMD, 32'h1);
    acc(1'b0, csp_pkg::OFF_STATUS, 32'h0);
    chk("owned busy", 32'h3, {30'h0, q[1:0]});
    acc(1'b1, csp_pkg::OFF_CAL_CMD, 32'h2);
    acc(1'b0, csp_pkg::OFF_STATUS, 32'h0);
    chk("aborted", 32'h0, {31'h0, q[1]});
    acc(1'b1, csp_pkg::OFF_CAL_CMD, 32'h0);
    rdc("act period", csp_pkg::OFF_ACT_PERIOD, 32'h50);
    meas(200, 100);
    en <= 1'b1;
    acc(1'b1, csp_pkg::OFF_CAL_CMD, 32'h1);
    for (int i = 0; i < 600; i++) begin
      acc(1'b0, csp_pkg::OFF_STATUS, 32'h0);
      if (q[1] === 1'b0) break;
    end
    chk("cal done", 32'h0, {31'h0, q[1]});
    acc(1'b0, csp_pkg::OFF_ACT_WIDTH, 32'h0);
    chk("zero width", 32'h1, {31'h0, q >= 32'h29 && q <= 32'h2C});
    acc(1'b0, csp_pkg::OFF_ACT_SLOPE, 32'h0);
    chk("slope sign", 32'h1, {31'h0, q[31]});
    en <= 1'b0;
  endtask

  task automatic t_fac;
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rdc("ctrl rst", csp_pkg::OFF_CTRL, 32'h1);
    rdc("boot load", csp_pkg::OFF_ACT_PERIOD, 32'h50);
    acc(1'b1, csp_pkg::OFF_FACTORY, 32'h1);
    rdc("keep cal", csp_pkg::OFF_ACT_PERIOD, 32'h50);
    acc(1'b1, csp_pkg::OFF_FACTORY, 32'h3);
    rdc("restored", csp_pkg::OFF_ACT_PERIOD, 32'h1130);
    rdc("restored w", csp_pkg::OFF_CAL_WIDTH, 32'h898);
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_switch;
    t_range;
    t_manual;
    t_cal;
    t_fac;
    stop_test;
  end
endmodule
